/* bench/dsp_sink.sv */
// Remote controller model that takes the response bytes and stalls on request.
// Assumes the packer's valid/ready byte stream on the one system clock.
`timescale 1ns/1ns
`default_nettype none

module dsp_sink (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       stall_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       valid_i,
   input  wire logic       last_i,
   output logic            ready_o
);
   logic [7:0] got [0:27];
   logic       got_last [0:27];
   int         idx;
   int         n_rx;
   int         tick;

   initial
   begin
      ready_o = 1'b0;
      idx = 0;
      n_rx = 0;
      tick = 0;
   end

   // A byte counts only at an edge where valid and ready are both high.
   always @(posedge core_clk_i)
   begin
      if (rst_i === 1'b0 && valid_i === 1'b1 && ready_o === 1'b1)
      begin
         got[idx] = byte_i;
         got_last[idx] = last_i;
         n_rx = n_rx + 1;
         idx = (idx == 27) ? 0 : idx + 1;
      end
      tick = tick + 1;
      #1;
      ready_o = !stall_i || (tick % 3 != 0);
   end
endmodule : dsp_sink
`default_nettype wire

/* bench/tb_demod_status_response_packer.sv */
// Self-checking bench for the status response packer.
// Assumes dsp_packer with its latch bank and the dsp_sink byte taker.
`timescale 1ns/1ns
`default_nettype none

module tb_demod_status_response_packer;
   logic        core_clk_i, rst_i, start_i, byte_ready_i;
   logic [15:0] raw_ber_mant_i, cor_ber_mant_i, tp_ber_mant_i, ebno_i;
   logic [7:0]  raw_ber_exp_i, cor_ber_exp_i, tp_ber_exp_i;
   logic        ber_valid_i, tp_ber_valid_i;
   logic [1:0]  ebno_qual_i, level_cmp_i, ctrl_mode_i;
   logic [31:0] freq_offset_i;
   logic [7:0]  fill_pct_i, level_db_i, ins_alarm_i, agc_i;
   logic        mf_loss_i, fs_loss_i, prompt_alarm_i, service_alarm_i;
   logic [3:0]  bwd_alarm_i;
   logic        latch_clr_i, crc_mode_i, ins_bwd_alarm_i, stall;
   logic [7:0]  byte_o, frm_latched_o, lat_m;
   logic        byte_valid_o, byte_last_o, busy_o, done_o;
   logic [7:0]  exp_b [0:27];
   int          failures, checks_done, cycles;

   dsp_packer dut_u (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i),
      .byte_ready_i(byte_ready_i), .raw_ber_mant_i(raw_ber_mant_i),
      .raw_ber_exp_i(raw_ber_exp_i), .cor_ber_mant_i(cor_ber_mant_i),
      .cor_ber_exp_i(cor_ber_exp_i), .tp_ber_mant_i(tp_ber_mant_i),
      .tp_ber_exp_i(tp_ber_exp_i), .ber_valid_i(ber_valid_i),
      .tp_ber_valid_i(tp_ber_valid_i), .ebno_i(ebno_i), .ebno_qual_i(ebno_qual_i),
      .freq_offset_i(freq_offset_i), .fill_pct_i(fill_pct_i), .level_db_i(level_db_i),
      .level_cmp_i(level_cmp_i), .mf_loss_i(mf_loss_i), .fs_loss_i(fs_loss_i),
      .prompt_alarm_i(prompt_alarm_i), .service_alarm_i(service_alarm_i),
      .bwd_alarm_i(bwd_alarm_i), .latch_clr_i(latch_clr_i), .ctrl_mode_i(ctrl_mode_i),
      .ins_alarm_i(ins_alarm_i), .crc_mode_i(crc_mode_i),
      .ins_bwd_alarm_i(ins_bwd_alarm_i), .agc_i(agc_i), .byte_o(byte_o),
      .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o), .busy_o(busy_o),
      .done_o(done_o), .frm_latched_o(frm_latched_o)
   );

   dsp_sink sink_u (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .stall_i(stall), .byte_i(byte_o),
      .valid_i(byte_valid_o), .last_i(byte_last_o), .ready_o(byte_ready_i)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checks_done = checks_done + 1;
      if (seen !== expv)
      begin
         failures = failures + 1;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, expv);
      end
   endtask : check

   task automatic wrap_up;
      $display("Checks done %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // Expected bytes come from the inputs held at the start edge.
   task automatic build_exp;
      logic [31:0] mag;
      logic [7:0]  frm;
      mag = freq_offset_i[31] ? (~freq_offset_i + 32'h0000_0001) : freq_offset_i;
      frm = {2'h0, service_alarm_i, prompt_alarm_i,
             ber_valid_i && (cor_ber_exp_i <= 8'h03), 1'b0, fs_loss_i, mf_loss_i};
      {exp_b[0], exp_b[1]} = raw_ber_mant_i;
      {exp_b[2], exp_b[3]} = cor_ber_mant_i;
      {exp_b[4], exp_b[5]} = ebno_i;
      {exp_b[6], exp_b[7], exp_b[8], exp_b[9]} = mag;
      {exp_b[10], exp_b[11]} = tp_ber_mant_i;
      exp_b[12] = raw_ber_exp_i;
      exp_b[13] = cor_ber_exp_i;
      exp_b[14] = tp_ber_exp_i;
      exp_b[15] = {7'h00, freq_offset_i[31]};
      exp_b[16] = {4'h0, ebno_qual_i, tp_ber_valid_i, ber_valid_i};
      exp_b[17] = (fill_pct_i > 8'h64) ? 8'h64 : fill_pct_i;
      exp_b[18] = level_db_i;
      exp_b[19] = (level_cmp_i == 2'h1) ? 8'h01 : (level_cmp_i == 2'h2) ? 8'hFF : 8'h00;
      exp_b[20] = frm;
      exp_b[21] = {4'h0, bwd_alarm_i};
      exp_b[22] = lat_m | frm;
      exp_b[23] = {6'h00, ctrl_mode_i};
      exp_b[24] = frm;
      exp_b[25] = crc_mode_i ? ins_alarm_i : (ins_alarm_i & 8'hFB);
      exp_b[26] = {7'h00, ins_bwd_alarm_i};
      exp_b[27] = agc_i;
      lat_m = lat_m | frm;
   endtask : build_exp

   // Entered just after an edge; a start is held back until the done cycle is over.
   task automatic run_case(input logic [7:0] kb);
      int n;
      // The done cycle still refuses a start, so let it pass before requesting again.
      if (done_o === 1'b1)
      begin
         @(posedge core_clk_i);
         #1;
      end
      raw_ber_mant_i = 16'hA1B2 ^ {8'h00, kb};
      raw_ber_exp_i = 8'h10 + kb;
      cor_ber_mant_i = 16'hC3D4;
      cor_ber_exp_i = 8'h02 + kb;
      tp_ber_mant_i = 16'h5E6F;
      tp_ber_exp_i = 8'h20 + kb;
      ber_valid_i = (kb != 8'h01);
      tp_ber_valid_i = kb[1];
      ebno_i = 16'h0123 + {8'h00, kb};
      ebno_qual_i = kb[1:0];
      freq_offset_i = kb[0] ? 32'h0012_3456 : 32'hFFFF_F000 - {24'h00_0000, kb};
      fill_pct_i = kb * 8'h32;
      level_db_i = 8'h40 + kb;
      level_cmp_i = kb[1:0];
      {service_alarm_i, prompt_alarm_i, fs_loss_i, mf_loss_i} = 4'h1 << kb[1:0];
      bwd_alarm_i = 4'h9 ^ kb[3:0];
      ctrl_mode_i = kb[1:0];
      ins_alarm_i = 8'hFF ^ kb;
      crc_mode_i = kb[0];
      ins_bwd_alarm_i = ~kb[0];
      agc_i = 8'h9A + kb;
      stall = kb[0];
      start_i = 1'b1;
      build_exp();
      @(posedge core_clk_i);
      #1;
      start_i = 1'b0;
      // Disturbing fields after the start edge must not reach the response.
      raw_ber_mant_i = ~raw_ber_mant_i;
      freq_offset_i = ~freq_offset_i;
      agc_i = ~agc_i;
      fill_pct_i = 8'h07;
      n = 0;
      while (done_o !== 1'b1 && n < 200)
      begin
         @(posedge core_clk_i);
         #1;
         n = n + 1;
      end
      check(done_o, 1'b1);
      check(busy_o, 1'b0);
      for (int i = 0; i < 15; i++)
         check(sink_u.got[i], exp_b[i]);
      for (int i = 15; i < 20; i++)
         check(sink_u.got[i], exp_b[i]);
      for (int i = 20; i < 24; i++)
         check(sink_u.got[i], exp_b[i]);
      for (int i = 24; i < 28; i++)
         check(sink_u.got[i], exp_b[i]);
      check(sink_u.got_last[27], 1'b1);
      check(sink_u.got_last[26], 1'b0);
      check(sink_u.n_rx, 28 * (kb + 1));
      $display("Test response case %0d ended", kb);
   endtask : run_case

   initial
   begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i)
   begin
      cycles = cycles + 1;
      if (cycles >= 3000)
      begin
         failures = failures + 1;
         wrap_up();
      end
   end

   initial
   begin
      {raw_ber_mant_i, cor_ber_mant_i, tp_ber_mant_i, ebno_i, freq_offset_i} = '0;
      {raw_ber_exp_i, cor_ber_exp_i, tp_ber_exp_i, fill_pct_i, level_db_i} = '0;
      {ebno_qual_i, level_cmp_i, ctrl_mode_i, ins_alarm_i, agc_i, bwd_alarm_i} = '0;
      {ber_valid_i, tp_ber_valid_i, mf_loss_i, fs_loss_i, prompt_alarm_i} = '0;
      {service_alarm_i, latch_clr_i, crc_mode_i, ins_bwd_alarm_i, start_i} = '0;
      {stall, failures, checks_done, cycles, lat_m} = '0;
      rst_i = 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1;
      rst_i = 1'b0;
      check({byte_valid_o, busy_o, done_o, byte_last_o}, 4'h0);
      check(frm_latched_o, 8'h00);
      for (int k = 0; k < 4; k++)
         run_case(k[7:0]);
      {service_alarm_i, prompt_alarm_i, fs_loss_i, mf_loss_i, ber_valid_i} = '0;
      repeat (2) @(posedge core_clk_i);
      #1;
      check(frm_latched_o, lat_m);
      fs_loss_i = 1'b1;
      latch_clr_i = 1'b1;
      repeat (2) @(posedge core_clk_i);
      #1;
      check(frm_latched_o, 8'h02);
      fs_loss_i = 1'b0;
      @(posedge core_clk_i);
      #1;
      check(frm_latched_o, 8'h00);
      latch_clr_i = 1'b0;
      $display("Test latched alarms ended");
      wrap_up();
   end
endmodule : tb_demod_status_response_packer
`default_nettype wire

/* rtl/dsp_latch.sv */
// Bank of sticky alarm bits that follow a current alarm vector.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module dsp_latch #(
   parameter int W = 8
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] cur_i,
   input  wire logic         clr_i,
   output logic      [W-1:0] lat_o
);

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         // A failure in the clearing cycle wins, so no event is lost.
         always_ff @(posedge core_clk_i)
         begin
            if (rst_i)
               lat_o[g] <= 1'b0;
            else if (cur_i[g])
               lat_o[g] <= 1'b1;
            else if (clr_i)
               lat_o[g] <= 1'b0;
         end

         a_latch_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
            lat_o[g] && !clr_i |=> lat_o[g])
            else $error("latched alarm dropped without clear");
         a_latch_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
            cur_i[g] |=> lat_o[g] [*1] ##1 (lat_o[g] || $past(clr_i)))
            else $error("latched alarm did not set on fail");
      end
   endgenerate

endmodule : dsp_latch

`default_nettype wire

/* rtl/dsp_packer.sv */
// Demodulator status response packer: snapshots all fields and emits them a byte at a time.
// Assumes synchronous inputs from the measurement logic and a byte sink with valid/ready.
`include "dsp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module dsp_packer #(
   parameter int NUM_BYTES = `DSP_NUM_BYTES
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        start_i,
   input  wire logic        byte_ready_i,
   input  wire logic [15:0] raw_ber_mant_i,
   input  wire logic [7:0]  raw_ber_exp_i,
   input  wire logic [15:0] cor_ber_mant_i,
   input  wire logic [7:0]  cor_ber_exp_i,
   input  wire logic [15:0] tp_ber_mant_i,
   input  wire logic [7:0]  tp_ber_exp_i,
   input  wire logic        ber_valid_i,
   input  wire logic        tp_ber_valid_i,
   input  wire logic [15:0] ebno_i,
   input  wire logic [1:0]  ebno_qual_i,
   input  wire logic [31:0] freq_offset_i,
   input  wire logic [7:0]  fill_pct_i,
   input  wire logic [7:0]  level_db_i,
   input  wire logic [1:0]  level_cmp_i,
   input  wire logic        mf_loss_i,
   input  wire logic        fs_loss_i,
   input  wire logic        prompt_alarm_i,
   input  wire logic        service_alarm_i,
   input  wire logic [3:0]  bwd_alarm_i,
   input  wire logic        latch_clr_i,
   input  wire logic [1:0]  ctrl_mode_i,
   input  wire logic [7:0]  ins_alarm_i,
   input  wire logic        crc_mode_i,
   input  wire logic        ins_bwd_alarm_i,
   input  wire logic [7:0]  agc_i,
   output logic      [7:0]  byte_o,
   output logic             byte_valid_o,
   output logic             byte_last_o,
   output logic             busy_o,
   output logic             done_o,
   output logic      [7:0]  frm_latched_o
);

   function automatic logic [7:0] pick_byte(input logic [31:0] val, input int k);
      pick_byte = val[8*k +: 8];
   endfunction : pick_byte

   dsp_pkg::dsp_state_t state_ff;
   dsp_pkg::dsp_state_t nxt_state;
   logic [4:0]          idx_ff;
   logic [7:0]          snap_ff [0:NUM_BYTES-1];
   logic [7:0]          nxt_snap [0:NUM_BYTES-1];

   wire logic        take      = (state_ff == dsp_pkg::DSP_IDLE) && start_i;
   wire logic        accept    = byte_valid_o && byte_ready_i;
   wire logic        at_end    = (idx_ff == 5'(NUM_BYTES));
   wire logic        freq_neg  = freq_offset_i[31];
   wire logic [31:0] freq_mag  = freq_neg ? (32'h0 - freq_offset_i) : freq_offset_i;
   // Mantissa normalised to one leading digit, so exponent 3 or less means BER of 1E-3 or worse.
   wire logic        ber_alarm = ber_valid_i && (cor_ber_exp_i <= `DSP_BER_ALARM_EXP);
   wire logic [7:0]  fill_byte = (fill_pct_i > `DSP_FILL_MAX) ? `DSP_FILL_MAX : fill_pct_i;
   wire logic [7:0]  lvlq_byte =
      (dsp_pkg::dsp_lvl_cmp_t'(level_cmp_i) == dsp_pkg::DSP_LVL_GT) ? `DSP_LVLQ_GT :
      (dsp_pkg::dsp_lvl_cmp_t'(level_cmp_i) == dsp_pkg::DSP_LVL_LT) ? `DSP_LVLQ_LT :
      `DSP_LVLQ_EQ;
   wire logic [7:0]  frm_byte;
   wire logic [7:0]  stat_byte;
   wire logic [7:0]  ins_byte;
   wire logic [7:0]  ctrl_byte = {6'h00, ctrl_mode_i};

   assign frm_byte[`DSP_FRM_MF_LOSS] = mf_loss_i;
   assign frm_byte[`DSP_FRM_FS_LOSS] = fs_loss_i;
   assign frm_byte[2]                = 1'b0;
   assign frm_byte[`DSP_FRM_BER]     = ber_alarm;
   assign frm_byte[`DSP_FRM_PROMPT]  = prompt_alarm_i;
   assign frm_byte[`DSP_FRM_SERVICE] = service_alarm_i;
   assign frm_byte[7:6]              = 2'h0;

   assign stat_byte[`DSP_STAT_BER_OK] = ber_valid_i;
   assign stat_byte[`DSP_STAT_TP_OK]  = tp_ber_valid_i;
   assign stat_byte[3:2]              = ebno_qual_i;
   assign stat_byte[7:4]              = 4'h0;

   // CRC lock is only meaningful with CRC framing, so it is forced to pass otherwise.
   assign ins_byte[1:0]              = ins_alarm_i[1:0];
   assign ins_byte[`DSP_INS_CRC_LOCK] = ins_alarm_i[`DSP_INS_CRC_LOCK] && crc_mode_i;
   assign ins_byte[7:3]              = ins_alarm_i[7:3];

   dsp_latch #(
      .W (8)
   ) u_frm_latch (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cur_i      (frm_byte),
      .clr_i      (latch_clr_i),
      .lat_o      (frm_latched_o)
   );

   // Mantissas and multi-byte values go out most significant byte first.
   assign nxt_snap[`DSP_IX_RAW_MANT]     = raw_ber_mant_i[15:8];
   assign nxt_snap[`DSP_IX_RAW_MANT + 1] = raw_ber_mant_i[7:0];
   assign nxt_snap[`DSP_IX_COR_MANT]     = cor_ber_mant_i[15:8];
   assign nxt_snap[`DSP_IX_COR_MANT + 1] = cor_ber_mant_i[7:0];
   assign nxt_snap[`DSP_IX_EBNO]         = ebno_i[15:8];
   assign nxt_snap[`DSP_IX_EBNO + 1]     = ebno_i[7:0];
   assign nxt_snap[`DSP_IX_FREQ]         = pick_byte(freq_mag, 3);
   assign nxt_snap[`DSP_IX_FREQ + 1]     = pick_byte(freq_mag, 2);
   assign nxt_snap[`DSP_IX_FREQ + 2]     = pick_byte(freq_mag, 1);
   assign nxt_snap[`DSP_IX_FREQ + 3]     = pick_byte(freq_mag, 0);
   assign nxt_snap[`DSP_IX_TP_MANT]      = tp_ber_mant_i[15:8];
   assign nxt_snap[`DSP_IX_TP_MANT + 1]  = tp_ber_mant_i[7:0];
   assign nxt_snap[`DSP_IX_RAW_EXP]      = raw_ber_exp_i;
   assign nxt_snap[`DSP_IX_COR_EXP]      = cor_ber_exp_i;
   assign nxt_snap[`DSP_IX_TP_EXP]       = tp_ber_exp_i;
   assign nxt_snap[`DSP_IX_SIGN]         = freq_neg ? `DSP_SIGN_NEG : `DSP_SIGN_POS;
   assign nxt_snap[`DSP_IX_STAT]         = stat_byte;
   assign nxt_snap[`DSP_IX_FILL]         = fill_byte;
   assign nxt_snap[`DSP_IX_LEVEL]        = level_db_i;
   assign nxt_snap[`DSP_IX_LEVEL_Q]      = lvlq_byte;
   assign nxt_snap[`DSP_IX_FRM]          = frm_byte;
   assign nxt_snap[`DSP_IX_BWD]          = {4'h0, bwd_alarm_i};
   // The latched byte includes this cycle's failures, matching what the latch will hold next unless latch_clr_i is high.
   assign nxt_snap[`DSP_IX_FRM_LAT]      = frm_latched_o | frm_byte;
   assign nxt_snap[`DSP_IX_CTRL]         = ctrl_byte;
   assign nxt_snap[`DSP_IX_SVC]          = frm_byte;
   assign nxt_snap[`DSP_IX_INS]          = ins_byte;
   assign nxt_snap[`DSP_IX_INS_BWD]      = {7'h00, ins_bwd_alarm_i};
   assign nxt_snap[`DSP_IX_AGC]          = agc_i;

   genvar g;
   generate
      for (g = 0; g < NUM_BYTES; g++)
      begin : g_snap
         always_ff @(posedge core_clk_i)
         begin
            if (rst_i)
               snap_ff[g] <= `DSP_RST_BYTE;
            else if (take)
               snap_ff[g] <= nxt_snap[g];
         end
      end
   endgenerate

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         dsp_pkg::DSP_IDLE: if (start_i) nxt_state = dsp_pkg::DSP_SEND;
         dsp_pkg::DSP_SEND: if (accept && at_end) nxt_state = dsp_pkg::DSP_DONE;
         dsp_pkg::DSP_DONE: nxt_state = dsp_pkg::DSP_IDLE;
         default:           nxt_state = dsp_pkg::DSP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         state_ff <= dsp_pkg::DSP_IDLE;
      else
         state_ff <= nxt_state;
   end

   // The first byte is loaded straight from the live fields, the rest from the snapshot.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         byte_o       <= `DSP_RST_BYTE;
         byte_valid_o <= 1'b0;
         byte_last_o  <= 1'b0;
         idx_ff       <= 5'h00;
      end
      else if (take)
      begin
         byte_o       <= nxt_snap[0];
         byte_valid_o <= 1'b1;
         byte_last_o  <= 1'b0;
         idx_ff       <= 5'h01;
      end
      else if (accept && at_end)
      begin
         byte_valid_o <= 1'b0;
         byte_last_o  <= 1'b0;
      end
      else if (accept)
      begin
         byte_o      <= snap_ff[idx_ff];
         byte_last_o <= (idx_ff == 5'(NUM_BYTES - 1));
         idx_ff      <= idx_ff + 5'h01;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         busy_o <= (nxt_state == dsp_pkg::DSP_SEND);
         done_o <= (nxt_state == dsp_pkg::DSP_DONE);
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_sign_byte: assert property (take |=>
      snap_ff[`DSP_IX_SIGN] == ($past(freq_neg) ? 8'h01 : 8'h00))
      else $error("sign byte does not follow offset polarity");
   a_fill_limit: assert property (snap_ff[`DSP_IX_FILL] <= 8'h64)
      else $error("buffer fill above one hundred percent");
   a_level_qual: assert property (take |=> (snap_ff[`DSP_IX_LEVEL_Q] == 8'h00 ||
      snap_ff[`DSP_IX_LEVEL_Q] == 8'h01 || snap_ff[`DSP_IX_LEVEL_Q] == 8'hFF))
      else $error("level qualifier has an illegal code");
   a_status_rsvd: assert property (snap_ff[`DSP_IX_STAT][7:4] == 4'h0)
      else $error("reserved status bits are set");
   a_ber_valid: assert property (take && !ber_valid_i |=> !snap_ff[`DSP_IX_STAT][0])
      else $error("BER reported valid while invalid");
   a_frm_spare: assert property ((snap_ff[`DSP_IX_FRM][2] == 1'b0) &&
      (snap_ff[`DSP_IX_FRM][7:6] == 2'h0))
      else $error("spare framing alarm bits are set");
   a_ber_thresh: assert property (take && ber_valid_i && cor_ber_exp_i < 8'h03 |=>
      snap_ff[`DSP_IX_SVC][3] && snap_ff[`DSP_IX_FRM][3])
      else $error("BER alarm missing above threshold");
   a_crc_gate: assert property (take && !crc_mode_i |=> !snap_ff[`DSP_IX_INS][2])
      else $error("CRC lock fault reported outside CRC mode");
   a_bwd_spare: assert property (snap_ff[`DSP_IX_BWD][7:4] == 4'h0)
      else $error("backward alarm spares are set");
   a_byte_order: assert property (accept && !at_end && !take |=>
      byte_o == snap_ff[$past(idx_ff)])
      else $error("byte out of order");
   a_byte_hold: assert property (byte_valid_o && !byte_ready_i |=>
      byte_valid_o && $stable(byte_o))
      else $error("byte changed while stalled");
   a_last_done: assert property (accept && byte_last_o |=>
      !byte_valid_o ##0 done_o ##1 !busy_o)
      else $error("response did not end after last byte");
   // Field checks up to a_ctrl_byte compare the snapshot against the inputs held at the taking edge; the rest check spares, latch cover and done.
   a_tp_valid: assert property (take && !tp_ber_valid_i |=> !snap_ff[`DSP_IX_STAT][1])
      else $error("test-sequence BER reported valid while invalid");
   a_exp_bytes: assert property (take |=>
      snap_ff[`DSP_IX_RAW_EXP] == $past(raw_ber_exp_i) &&
      snap_ff[`DSP_IX_COR_EXP] == $past(cor_ber_exp_i) &&
      snap_ff[`DSP_IX_TP_EXP] == $past(tp_ber_exp_i))
      else $error("BER exponent byte does not match");
   a_mant_bytes: assert property (take |=>
      {snap_ff[`DSP_IX_COR_MANT], snap_ff[`DSP_IX_COR_MANT + 1]} == $past(cor_ber_mant_i))
      else $error("BER mantissa bytes do not match");
   a_ebno_bytes: assert property (take |=>
      {snap_ff[`DSP_IX_EBNO], snap_ff[`DSP_IX_EBNO + 1]} == $past(ebno_i))
      else $error("EbNo bytes do not match");
   a_level_byte: assert property (take |=> snap_ff[`DSP_IX_LEVEL] == $past(level_db_i))
      else $error("input level byte does not match");
   a_prompt_bit: assert property (take |=>
      snap_ff[`DSP_IX_FRM][`DSP_FRM_PROMPT] == $past(prompt_alarm_i))
      else $error("prompt alarm not in its framing bit");
   a_ctrl_byte: assert property (take |=>
      snap_ff[`DSP_IX_CTRL] == {6'h00, $past(ctrl_mode_i)})
      else $error("control source byte does not match");
   a_ins_bwd_spare: assert property (snap_ff[`DSP_IX_INS_BWD][7:1] == 7'h00)
      else $error("insert backward spares are set");
   a_lat_covers: assert property ((snap_ff[`DSP_IX_FRM_LAT] & snap_ff[`DSP_IX_FRM]) ==
      snap_ff[`DSP_IX_FRM])
      else $error("latched framing byte misses a current alarm");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done held longer than one cycle");

   c_start: cover property (take);
   c_stall: cover property (byte_valid_o && !byte_ready_i ##1 accept);
   c_full_resp: cover property (accept && byte_last_o ##1 done_o);
   c_neg_offset: cover property (take && freq_offset_i[31]);
   c_latch_clear: cover property (latch_clr_i && (frm_byte != 8'h00));

endmodule : dsp_packer

`default_nettype wire

/* rtl/dsp_pkg.sv */
// Types shared by the status response packer.
// Assumes nothing of its surroundings.
package dsp_pkg;

   typedef enum logic [1:0]
   {
      DSP_IDLE = 2'b00,
      DSP_SEND = 2'b01,
      DSP_DONE = 2'b11
   } dsp_state_t;

   typedef enum logic [1:0]
   {
      DSP_LVL_EQ = 2'b00,
      DSP_LVL_GT = 2'b01,
      DSP_LVL_LT = 2'b10
   } dsp_lvl_cmp_t;

   typedef enum logic [1:0]
   {
      DSP_CTRL_PANEL    = 2'b00,
      DSP_CTRL_TERMINAL = 2'b01,
      DSP_CTRL_COMPUTER = 2'b10
   } dsp_ctrl_t;

endpackage : dsp_pkg

/* rtl/dsp_regs.svh */
// Byte offsets, bit positions and coded values of the demodulator status response.
// Assumes it is included by bare name from rtl/ sources that use these macros.
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

`define DSP_NUM_BYTES      28
`define DSP_IX_RAW_MANT    0
`define DSP_IX_COR_MANT    2
`define DSP_IX_EBNO        4
`define DSP_IX_FREQ        6
`define DSP_IX_TP_MANT     10
`define DSP_IX_RAW_EXP     12
`define DSP_IX_COR_EXP     13
`define DSP_IX_TP_EXP      14
`define DSP_IX_SIGN        15
`define DSP_IX_STAT        16
`define DSP_IX_FILL        17
`define DSP_IX_LEVEL       18
`define DSP_IX_LEVEL_Q     19
`define DSP_IX_FRM         20
`define DSP_IX_BWD         21
`define DSP_IX_FRM_LAT     22
`define DSP_IX_CTRL        23
`define DSP_IX_SVC         24
`define DSP_IX_INS         25
`define DSP_IX_INS_BWD     26
`define DSP_IX_AGC         27

`define DSP_FRM_MF_LOSS    0
`define DSP_FRM_FS_LOSS    1
`define DSP_FRM_BER        3
`define DSP_FRM_PROMPT     4
`define DSP_FRM_SERVICE    5
`define DSP_STAT_BER_OK    0
`define DSP_STAT_TP_OK     1
`define DSP_STAT_EBNO_LSB  2
`define DSP_INS_CRC_LOCK   2

`define DSP_SIGN_POS       8'h00
`define DSP_SIGN_NEG       8'h01
`define DSP_LVLQ_EQ        8'h00
`define DSP_LVLQ_GT        8'h01
`define DSP_LVLQ_LT        8'hFF
`define DSP_FILL_MAX       8'h64
`define DSP_BER_ALARM_EXP  8'h03
`define DSP_RST_BYTE       8'h00

`endif
